// ### rtl/ddc_bank.sv
// Open-row table: one open flag and one row address per bank.
// Assumes strobes come from the decoder on the same clock edge.
`default_nettype none

module ddc_bank (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        reset,
  // Bank commands
  input  wire logic                        act,
  input  wire logic                        pre,
  input  wire logic                        pre_all,
  input  wire logic [ddc_pkg::BA_W-1:0]    ba,
  input  wire logic [ddc_pkg::ADDR_W-1:0]  row,
  // Auto precharge at burst end
  input  wire logic                        ap_close,
  input  wire logic [ddc_pkg::BA_W-1:0]    ap_ba,
  // Table state
  output logic [ddc_pkg::NBANK-1:0]        open_o,
  output logic [ddc_pkg::NBANK*ddc_pkg::ADDR_W-1:0] rows_o
);

  logic [ddc_pkg::ADDR_W-1:0] row_r [ddc_pkg::NBANK];
  logic [ddc_pkg::NBANK-1:0]  open_r;
  logic [ddc_pkg::NBANK-1:0]  open_nxt;

  // Activate wins over a same-cycle auto precharge of another burst
  always_comb begin
    open_nxt = open_r;
    if (ap_close) begin
      open_nxt[ap_ba] = 1'b0;
    end
    if (pre_all) begin
      open_nxt = '0;
    end else if (pre) begin
      open_nxt[ba] = 1'b0;
    end
    if (act) begin
      open_nxt[ba] = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      open_r <= '0;
    end else begin
      open_r <= open_nxt;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ddc_pkg::NBANK; i++) begin
        row_r[i] <= '0;
      end
    end else if (act) begin
      row_r[ba] <= row;
    end
  end

  always_comb begin
    for (int i = 0; i < ddc_pkg::NBANK; i++) begin
      rows_o[i*ddc_pkg::ADDR_W +: ddc_pkg::ADDR_W] = row_r[i];
    end
  end

  assign open_o = open_r;

endmodule : ddc_bank

`default_nettype wire

// ### rtl/ddc_decoder.sv
// DDR2 command decoder: samples the command pins each rising edge,
// decodes commands, tracks power state, bursts and open rows.
// Assumes a controller on the far side that keeps its own timing.
//
// Functional notes
// - Command comes only from CS#, RAS#, CAS#, WE#, CKE and A10 sampled each edge.
// - CS# high: no new command taken, running operations continue.
// - CS# low, others high: no-operation, nothing new registered.
// - Mode load: CKE high twice, all low; BA picks register, A is opcode.
// - CS# RAS# CAS# low, WE# high: refresh, or self refresh if CKE falls.
// - Self refresh ends when CKE returns high; exit is asynchronous.
// - Precharge closes addressed bank, or all banks when A10 high.
// - Read: RAS# high, CAS# low, WE# high; A10 high means auto precharge.
// - Write: RAS# high, CAS# low, WE# low; A10 high means auto precharge.
// - CKE fall with idle bus enters power-down; CKE rise with idle bus leaves it.
// - No refresh in power-down; controller bounds its duration.
// - Bursts of four run to completion and are never cut short.
// - ODT never affects decoding; termination is off in self refresh.
// - Activate opens the given row in the given bank until precharge.
`default_nettype none

module ddc_decoder (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       odt,
  input  wire logic [ddc_pkg::BA_W-1:0]   ba,
  input  wire logic [ddc_pkg::ADDR_W-1:0] addr,
  // Decoded command
  output var  ddc_pkg::ddc_cmd_s          cmd_o,
  output logic                            cmd_vld_o,
  output logic                            cmd_drop_o,
  // Mode register load
  output logic                            mode_wr_o,
  output logic [ddc_pkg::BA_W-1:0]        mode_sel_o,
  output logic [ddc_pkg::ADDR_W-1:0]      mode_op_o,
  // Refresh and power
  output logic                            refresh_o,
  output var  ddc_pkg::ddc_pwr_e          power_o,
  output logic                            rterm_on_o,
  // Bursts
  output logic                            burst_busy_o,
  output logic                            burst_rd_o,
  // Bank table
  output logic [ddc_pkg::NBANK-1:0]       bank_open_o,
  output logic [ddc_pkg::NBANK*ddc_pkg::ADDR_W-1:0] bank_rows_o
);

  function automatic ddc_pkg::ddc_cmd_e cmd_decode(
    input logic cp, input logic cc, input logic cs, input logic ras,
    input logic cas, input logic we, input logic a10);
    logic idle;
    idle = cs | (ras & cas & we);
    cmd_decode = ddc_pkg::CMD_ILL;
    if (!cp) begin
      cmd_decode = (cc && idle) ? ddc_pkg::CMD_WAKE : ddc_pkg::CMD_NOP;
    end else if (!cc) begin
      cmd_decode = idle ? ddc_pkg::CMD_PDE : ({ras, cas, we} == 3'h1) ?
                   ddc_pkg::CMD_SRE : ddc_pkg::CMD_ILL;
    end else if (cs) begin
      cmd_decode = ddc_pkg::CMD_DESEL;
    end else begin
      case ({ras, cas, we})
        3'h0:    cmd_decode = ddc_pkg::CMD_MODE;
        3'h1:    cmd_decode = ddc_pkg::CMD_REF;
        3'h2:    cmd_decode = a10 ? ddc_pkg::CMD_PREA : ddc_pkg::CMD_PRE;
        3'h3:    cmd_decode = ddc_pkg::CMD_ACT;
        3'h4:    cmd_decode = a10 ? ddc_pkg::CMD_WRA : ddc_pkg::CMD_WR;
        3'h5:    cmd_decode = a10 ? ddc_pkg::CMD_RDA : ddc_pkg::CMD_RD;
        3'h7:    cmd_decode = ddc_pkg::CMD_NOP;
        default: cmd_decode = ddc_pkg::CMD_ILL;
      endcase
    end
  endfunction : cmd_decode

  function automatic logic is_burst(input ddc_pkg::ddc_cmd_e c);
    is_burst = (c == ddc_pkg::CMD_RD) || (c == ddc_pkg::CMD_RDA) ||
               (c == ddc_pkg::CMD_WR) || (c == ddc_pkg::CMD_WRA);
  endfunction : is_burst

  ddc_pkg::ddc_pin_s pins_in;
  ddc_pkg::ddc_pin_s pin_m_r;
  ddc_pkg::ddc_pin_s pin_s_r;
  logic              cke_prev_r;
  ddc_pkg::ddc_cmd_e dec;
  ddc_pkg::ddc_pwr_e pwr_r;
  ddc_pkg::ddc_pwr_e pwr_nxt;
  ddc_pkg::ddc_cmd_s cmd_r;
  logic              cmd_vld_r;
  logic              cmd_drop_r;
  logic              mode_wr_r;
  logic [ddc_pkg::BA_W-1:0]   mode_sel_r;
  logic [ddc_pkg::ADDR_W-1:0] mode_op_r;
  logic              refresh_r;
  logic              rterm_r;
  logic [1:0]        bcnt_r;
  logic [1:0]        bcnt_nxt;
  logic              burst_busy_r;
  logic              burst_rd_r;
  logic              burst_ap_r;
  logic [ddc_pkg::BA_W-1:0] burst_ba_r;
  logic              sr_flag_r;
  logic              sr_clr;
  logic              sr_m_r;
  logic              sr_s_r;
  logic              sr_d_r;

  // Decode, acceptance and sequencing terms
  wire acc       = (pwr_r == ddc_pkg::PW_ACTIVE);
  wire a10       = pin_s_r.addr[ddc_pkg::A10_BIT];
  wire burst_req = acc && is_burst(dec);
  wire burst_ok  = (bcnt_r <= ddc_pkg::BCNT_LAST);
  wire burst_go  = burst_req && burst_ok;
  wire burst_rej = burst_req && !burst_ok;
  wire ap_close  = (bcnt_r == ddc_pkg::BCNT_LAST) && burst_ap_r;
  wire sre_go    = acc && (dec == ddc_pkg::CMD_SRE);
  wire sr_wake   = !sr_s_r && (sr_d_r || pin_s_r.cke);
  wire take      = acc && !burst_rej &&
                   (dec != ddc_pkg::CMD_NOP) && (dec != ddc_pkg::CMD_DESEL) &&
                   (dec != ddc_pkg::CMD_ILL);
  wire act_go    = acc && (dec == ddc_pkg::CMD_ACT);
  wire pre_go    = acc && (dec == ddc_pkg::CMD_PRE);
  wire prea_go   = acc && (dec == ddc_pkg::CMD_PREA);

  assign pins_in = '{cke: cke, cs_n: cs_n, ras_n: ras_n, cas_n: cas_n,
                     we_n: we_n, odt: odt, ba: ba, addr: addr};

  // ODT is deliberately not an argument of the decode
  assign dec = cmd_decode(cke_prev_r, pin_s_r.cke, pin_s_r.cs_n,
                          pin_s_r.ras_n, pin_s_r.cas_n, pin_s_r.we_n,
                          a10);

  // Two-stage sampling of every pin, then the previous CKE level
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pin_m_r    <= ddc_pkg::PIN_RST;
      pin_s_r    <= ddc_pkg::PIN_RST;
      cke_prev_r <= 1'b0;
    end else begin
      pin_m_r    <= pins_in;
      pin_s_r    <= pin_m_r;
      cke_prev_r <= pin_s_r.cke;
    end
  end

  // Self-refresh flag cleared straight by the CKE pin, so wake-up does
  // not wait for a clock that may be stopped during self refresh.
  assign sr_clr = reset | cke;

  always_ff @(posedge mclk or posedge sr_clr) begin
    if (sr_clr) begin
      sr_flag_r <= 1'b0;
    end else if (sre_go) begin
      sr_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sr_m_r <= 1'b0;
      sr_s_r <= 1'b0;
      sr_d_r <= 1'b0;
    end else begin
      sr_m_r <= sr_flag_r;
      sr_s_r <= sr_m_r;
      sr_d_r <= sr_s_r;
    end
  end

  // Power state
  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      ddc_pkg::PW_ACTIVE: begin
        if (dec == ddc_pkg::CMD_SRE) begin
          pwr_nxt = ddc_pkg::PW_SELF;
        end else if (dec == ddc_pkg::CMD_PDE) begin
          pwr_nxt = ddc_pkg::PW_DOWN;
        end
      end
      ddc_pkg::PW_DOWN:
        if (dec == ddc_pkg::CMD_WAKE) pwr_nxt = ddc_pkg::PW_ACTIVE;
      ddc_pkg::PW_SELF:
        if (sr_wake) pwr_nxt = ddc_pkg::PW_ACTIVE;
      default: pwr_nxt = ddc_pkg::PW_ACTIVE;
    endcase
  end

  // Burst counter: a new burst may join on the last beat of the old one
  assign bcnt_nxt = burst_go ? ddc_pkg::BCNT_LOAD :
                    (bcnt_r != ddc_pkg::BCNT_IDLE) ? bcnt_r - 2'h1 :
                    ddc_pkg::BCNT_IDLE;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      pwr_r      <= ddc_pkg::PW_ACTIVE;
      bcnt_r     <= ddc_pkg::BCNT_IDLE;
      burst_busy_r <= 1'b0;
      burst_rd_r <= 1'b0;
      burst_ap_r <= 1'b0;
      burst_ba_r <= '0;
    end else begin
      pwr_r  <= pwr_nxt;
      bcnt_r <= bcnt_nxt;
      burst_busy_r <= (bcnt_nxt != ddc_pkg::BCNT_IDLE);
      if (burst_go) begin
        burst_rd_r <= (dec == ddc_pkg::CMD_RD) || (dec == ddc_pkg::CMD_RDA);
        burst_ap_r <= (dec == ddc_pkg::CMD_RDA) ||
                      (dec == ddc_pkg::CMD_WRA);
        burst_ba_r <= pin_s_r.ba;
      end
    end
  end

  // Registered command outputs
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cmd_r      <= ddc_pkg::CMD_RST;
      cmd_vld_r  <= 1'b0;
      cmd_drop_r <= 1'b0;
      mode_wr_r  <= 1'b0;
      mode_sel_r <= '0;
      mode_op_r  <= '0;
      refresh_r  <= 1'b0;
      rterm_r    <= 1'b0;
    end else begin
      cmd_r      <= '{code: dec, ba: pin_s_r.ba, addr: pin_s_r.addr};
      cmd_vld_r  <= take;
      cmd_drop_r <= burst_rej;
      mode_wr_r  <= acc && (dec == ddc_pkg::CMD_MODE);
      if (acc && (dec == ddc_pkg::CMD_MODE)) begin
        mode_sel_r <= pin_s_r.ba;
        mode_op_r  <= pin_s_r.addr;
      end
      refresh_r  <= acc && (dec == ddc_pkg::CMD_REF);
      rterm_r    <= pin_s_r.odt && (pwr_nxt != ddc_pkg::PW_SELF);
    end
  end

  ddc_bank u_bank (
    .mclk     (mclk),
    .reset    (reset),
    .act      (act_go),
    .pre      (pre_go),
    .pre_all  (prea_go),
    .ba       (pin_s_r.ba),
    .row      (pin_s_r.addr),
    .ap_close (ap_close),
    .ap_ba    (burst_ba_r),
    .open_o   (bank_open_o),
    .rows_o   (bank_rows_o)
  );

  assign cmd_o        = cmd_r;
  assign cmd_vld_o    = cmd_vld_r;
  assign cmd_drop_o   = cmd_drop_r;
  assign mode_wr_o    = mode_wr_r;
  assign mode_sel_o   = mode_sel_r;
  assign mode_op_o    = mode_op_r;
  assign refresh_o    = refresh_r;
  assign power_o      = pwr_r;
  assign rterm_on_o   = rterm_r;
  assign burst_busy_o = burst_busy_r;
  assign burst_rd_o   = burst_rd_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  sequence s_burst_start;
    burst_go;
  endsequence
  sequence s_burst_run;
    burst_busy_o [*2];
  endsequence
  a_sample_edge: assert property (
    cmd_vld_o |-> cmd_o.code == $past(dec))
    else $error("decoded command not from sampled pins");
  a_deselect_quiet: assert property (
    (dec == ddc_pkg::CMD_DESEL) |=> !cmd_vld_o && !mode_wr_o)
    else $error("deselect registered a command");
  a_nop_quiet: assert property (
    (dec == ddc_pkg::CMD_NOP) |=> !cmd_vld_o && !refresh_o)
    else $error("no-operation registered a command");
  a_mode_load: assert property (
    (acc && dec == ddc_pkg::CMD_MODE) |=> mode_wr_o &&
      mode_sel_o == $past(pin_s_r.ba) &&
      mode_op_o == $past(pin_s_r.addr))
    else $error("mode load not captured");
  a_self_entry: assert property (
    sre_go |=> power_o == ddc_pkg::PW_SELF ##3 sr_d_r)
    else $error("self refresh not entered");
  a_self_exit: assert property (
    (power_o == ddc_pkg::PW_SELF && sr_wake) |=>
      power_o == ddc_pkg::PW_ACTIVE)
    else $error("self refresh exit missed");
  a_prech_all: assert property (
    prea_go |=> bank_open_o == '0)
    else $error("precharge all left a bank open");
  a_read_ap: assert property (
    (acc && burst_ok && dec == ddc_pkg::CMD_RDA) |=> burst_rd_o &&
      burst_ap_r ##2 !bank_open_o[$past(burst_ba_r, 2)])
    else $error("read auto precharge failed");
  a_write_ap: assert property (
    (acc && burst_ok && dec == ddc_pkg::CMD_WR) |=>
      !burst_rd_o && !burst_ap_r)
    else $error("write took wrong precharge mode");
  a_power_down: assert property (
    (acc && dec == ddc_pkg::CMD_PDE) |=> power_o == ddc_pkg::PW_DOWN
      ##0 (dec != ddc_pkg::CMD_WAKE) [*1] |=> power_o == ddc_pkg::PW_DOWN)
    else $error("power-down entry or hold failed");
  a_pd_norefresh: assert property (
    (power_o != ddc_pkg::PW_ACTIVE) |=> !refresh_o)
    else $error("refresh while powered down");
  a_burst_len: assert property (
    s_burst_start |=> s_burst_run)
    else $error("burst cut short");
  a_rterm_self: assert property (
    (power_o == ddc_pkg::PW_SELF) |-> !rterm_on_o)
    else $error("termination on in self refresh");
  a_act_open: assert property (
    act_go |=> bank_open_o[$past(pin_s_r.ba)] &&
      bank_rows_o[$past(pin_s_r.ba)*ddc_pkg::ADDR_W +: ddc_pkg::ADDR_W]
        == $past(pin_s_r.addr))
    else $error("activate did not open the row");

endmodule : ddc_decoder

`default_nettype wire

// ### rtl/ddc_pkg.sv
// Shared constants and types for the DDR2 command decoder.
// Assumes a single 10 MHz clock domain and one asynchronous reset.
`default_nettype none

package ddc_pkg;

  localparam int NBANK     = 4;
  localparam int BA_W      = 2;
  localparam int ADDR_W    = 13;
  localparam int A10_BIT   = 10;
  localparam int BURST_LEN = 4;
  localparam int BURST_CYC = BURST_LEN / 2;

  // Burst counter load and last-beat values
  localparam logic [1:0] BCNT_LOAD = 2'(BURST_CYC);
  localparam logic [1:0] BCNT_LAST = 2'h1;
  localparam logic [1:0] BCNT_IDLE = 2'h0;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_DESEL = 4'h1,
    CMD_MODE  = 4'h2,
    CMD_REF   = 4'h3,
    CMD_SRE   = 4'h4,
    CMD_WAKE  = 4'h5,
    CMD_PRE   = 4'h6,
    CMD_PREA  = 4'h7,
    CMD_ACT   = 4'h8,
    CMD_WR    = 4'h9,
    CMD_WRA   = 4'hA,
    CMD_RD    = 4'hB,
    CMD_RDA   = 4'hC,
    CMD_PDE   = 4'hD,
    CMD_ILL   = 4'hF
  } ddc_cmd_e;

  typedef enum logic [1:0] {
    PW_ACTIVE = 2'h0,
    PW_DOWN   = 2'h1,
    PW_SELF   = 2'h2
  } ddc_pwr_e;

  typedef struct packed {
    logic              cke;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              odt;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddc_pin_s;

  typedef struct packed {
    ddc_cmd_e          code;
    logic [BA_W-1:0]   ba;
    logic [ADDR_W-1:0] addr;
  } ddc_cmd_s;

  // Pins read as an idle, deselected bus with CKE low until sampled
  localparam ddc_pin_s PIN_RST = '{cke: 1'b0, cs_n: 1'b1, ras_n: 1'b1,
                                   cas_n: 1'b1, we_n: 1'b1, odt: 1'b0,
                                   ba: 2'h0, addr: 13'h0000};
  localparam ddc_cmd_s CMD_RST = '{code: CMD_NOP, ba: 2'h0,
                                   addr: 13'h0000};

endpackage : ddc_pkg

`default_nettype wire

// ### tb/ddc_ctrl_model.sv
// Controller-side model: drives the command, bank and address pins.
// Assumes the bench calls drive once per cycle, never twice per edge.
`default_nettype none

module ddc_ctrl_model (
  // Clock
  input  wire logic           mclk,
  // Pins toward the device
  output var ddc_pkg::ddc_pin_s pins
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus starts as a selected, idle bus so no pin is ever left floating
  initial begin
    pins = '{cke: 1'b1, cs_n: 1'b0, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
             odt: 1'b0, ba: 2'h0, addr: 13'h0000};
  end

  // One pattern per rising edge, held until the next call changes it
  task automatic drive(input ddc_pkg::ddc_pin_s p);
    @(posedge mclk);
    pins <= p;
  endtask : drive

  // Mode loads come only with banks idle, followed by idle cycles
  task automatic load_mode(input ddc_pkg::ddc_pin_s p,
                           input ddc_pkg::ddc_pin_s idle);
    drive(p);
    repeat (3) drive(idle);
  endtask : load_mode

endmodule : ddc_ctrl_model

`default_nettype wire

// ### tb/ddc_decoder_tb.sv
// Self-checking bench for the command decoder.
// Assumes decoded results show two edges after the pins are sampled.
`default_nettype none

`define CHK(what, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); \
    end \
  end

module ddc_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    ddc_pkg::ddc_pin_s pin;
    ddc_pkg::ddc_cmd_e code;
    logic              vld;
  } ddc_row_s;

  // Five control bits {cke, cs_n, ras_n, cas_n, we_n}
  localparam logic [4:0] P_NOP = 5'h17;
  localparam logic [4:0] P_DES = 5'h1F;
  localparam logic [4:0] P_MOD = 5'h10;
  localparam logic [4:0] P_REF = 5'h11;
  localparam logic [4:0] P_PRE = 5'h12;
  localparam logic [4:0] P_ACT = 5'h13;
  localparam logic [4:0] P_WR  = 5'h14;
  localparam logic [4:0] P_RD  = 5'h15;
  localparam logic [4:0] P_ILL = 5'h16;

  logic              mclk;
  logic              reset;
  ddc_pkg::ddc_pin_s pins;
  ddc_pkg::ddc_cmd_s cmd_o;
  ddc_pkg::ddc_pwr_e power_o;
  logic              cmd_vld_o;
  logic              cmd_drop_o;
  logic              mode_wr_o;
  logic [1:0]        mode_sel_o;
  logic [12:0]       mode_op_o;
  logic              refresh_o;
  logic              rterm_on_o;
  logic              burst_busy_o;
  logic              burst_rd_o;
  logic [3:0]        bank_open_o;
  logic [51:0]       bank_rows_o;
  int                bad_count;
  int                checked;
  ddc_row_s          rows[13];

  ddc_ctrl_model ctl (.mclk(mclk), .pins(pins));

  ddc_decoder DUT (
    .mclk(mclk), .reset(reset), .cke(pins.cke), .cs_n(pins.cs_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
    .odt(pins.odt), .ba(pins.ba), .addr(pins.addr), .cmd_o(cmd_o),
    .cmd_vld_o(cmd_vld_o), .cmd_drop_o(cmd_drop_o),
    .mode_wr_o(mode_wr_o), .mode_sel_o(mode_sel_o),
    .mode_op_o(mode_op_o), .refresh_o(refresh_o), .power_o(power_o),
    .rterm_on_o(rterm_on_o), .burst_busy_o(burst_busy_o),
    .burst_rd_o(burst_rd_o), .bank_open_o(bank_open_o),
    .bank_rows_o(bank_rows_o)
  );

  function automatic ddc_pkg::ddc_pin_s pat(input logic [4:0] c,
      input logic [1:0] b, input logic [12:0] a, input logic o);
    pat = '{cke: c[4], cs_n: c[3], ras_n: c[2], cas_n: c[1],
            we_n: c[0], odt: o, ba: b, addr: a};
  endfunction : pat

  // Pattern, three idle cycles, then look just after the decode edge
  task automatic run(input ddc_pkg::ddc_pin_s p);
    ctl.drive(p);
    repeat (3) ctl.drive(pat(P_NOP, 2'h0, 13'h0000, 1'b0));
    #1;
  endtask : run

  // One more cycle with the given pattern, then settle
  task automatic hold(input logic [4:0] c);
    ctl.drive(pat(c, 2'h0, 13'h0000, 1'b0));
    #1;
  endtask : hold

  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // About 110 cycles of tests; far beyond that means a hang
  initial begin
    repeat (3000) @(posedge mclk);
    bad_count++;
    conclude();
  end

  initial begin
    reset = 1'b1;
    bad_count = 0;
    checked = 0;
    rows[0]  = '{pat(P_MOD, 2'h1, 13'h0A5C, 1'b0), ddc_pkg::CMD_MODE, 1'b1};
    rows[1]  = '{pat(P_REF, 2'h3, 13'h1FFF, 1'b1), ddc_pkg::CMD_REF, 1'b1};
    rows[2]  = '{pat(P_ACT, 2'h1, 13'h1234, 1'b0), ddc_pkg::CMD_ACT, 1'b1};
    rows[3]  = '{pat(P_WR, 2'h1, 13'h0008, 1'b1), ddc_pkg::CMD_WR, 1'b1};
    rows[4]  = '{pat(P_RD, 2'h1, 13'h0010, 1'b0), ddc_pkg::CMD_RD, 1'b1};
    rows[5]  = '{pat(P_WR, 2'h1, 13'h0400, 1'b0), ddc_pkg::CMD_WRA, 1'b1};
    rows[6]  = '{pat(P_ACT, 2'h2, 13'h0777, 1'b0), ddc_pkg::CMD_ACT, 1'b1};
    rows[7]  = '{pat(P_RD, 2'h2, 13'h0404, 1'b1), ddc_pkg::CMD_RDA, 1'b1};
    rows[8]  = '{pat(P_PRE, 2'h0, 13'h0000, 1'b0), ddc_pkg::CMD_PRE, 1'b1};
    rows[9]  = '{pat(P_PRE, 2'h1, 13'h0400, 1'b0), ddc_pkg::CMD_PREA, 1'b1};
    rows[10] = '{pat(P_NOP, 2'h3, 13'h1FFF, 1'b1), ddc_pkg::CMD_NOP, 1'b0};
    rows[11] = '{pat(P_DES, 2'h0, 13'h0400, 1'b0), ddc_pkg::CMD_DESEL, 1'b0};
    rows[12] = '{pat(P_ILL, 2'h1, 13'h0000, 1'b0), ddc_pkg::CMD_ILL, 1'b0};
    repeat (3) @(posedge mclk);
    #1;
    `CHK("rst_code", ddc_pkg::CMD_NOP, cmd_o.code)
    `CHK("rst_vld", 1'b0, cmd_vld_o)
    `CHK("rst_pwr", ddc_pkg::PW_ACTIVE, power_o)
    `CHK("rst_open", 4'h0, bank_open_o)
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    ctl.load_mode(pat(P_NOP, 2'h0, 13'h0000, 1'b0),
                  pat(P_NOP, 2'h0, 13'h0000, 1'b0));
    for (int i = 0; i < 13; i++) begin
      run(rows[i].pin);
      `CHK("code", rows[i].code, cmd_o.code)
      `CHK("vld", rows[i].vld, cmd_vld_o)
      `CHK("mode_wr", rows[i].code == ddc_pkg::CMD_MODE, mode_wr_o)
      `CHK("refresh", rows[i].code == ddc_pkg::CMD_REF, refresh_o)
      `CHK("rterm", rows[i].pin.odt, rterm_on_o)
      if (rows[i].vld) begin
        `CHK("target", rows[i].pin.ba, cmd_o.ba)
        `CHK("address", rows[i].pin.addr, cmd_o.addr)
      end
    end
    `CHK("mode_sel", 2'h1, mode_sel_o)
    `CHK("mode_op", 13'h0A5C, mode_op_o)
    `CHK("ap_closed", 4'h0, bank_open_o)
    // Banks opened, then closed singly and all at once
    run(pat(P_ACT, 2'h3, 13'h1ABC, 1'b0));
    run(pat(P_ACT, 2'h0, 13'h0005, 1'b0));
    `CHK("open", 4'h9, bank_open_o)
    `CHK("row3", 13'h1ABC, bank_rows_o[39 +: 13])
    `CHK("row0", 13'h0005, bank_rows_o[0 +: 13])
    run(pat(P_PRE, 2'h3, 13'h0000, 1'b0));
    `CHK("pre_one", 4'h1, bank_open_o)
    run(pat(P_PRE, 2'h2, 13'h0400, 1'b0));
    `CHK("pre_all", 4'h0, bank_open_o)
    // Read on the very next cycle is refused while a burst runs
    ctl.drive(pat(P_RD, 2'h0, 13'h0020, 1'b0));
    ctl.drive(pat(P_RD, 2'h0, 13'h0024, 1'b0));
    hold(P_NOP);
    hold(P_NOP);
    `CHK("rd_vld", 1'b1, cmd_vld_o)
    `CHK("rd_busy", 1'b1, burst_busy_o)
    `CHK("rd_dir", 1'b1, burst_rd_o)
    hold(P_NOP);
    `CHK("cut_drop", 1'b1, cmd_drop_o)
    `CHK("cut_vld", 1'b0, cmd_vld_o)
    `CHK("cut_busy", 1'b1, burst_busy_o)
    hold(P_NOP);
    `CHK("rd_done", 1'b0, burst_busy_o)
    // Writes joined every two cycles, with a deselect in between
    ctl.drive(pat(P_WR, 2'h1, 13'h0030, 1'b0));
    ctl.drive(pat(P_DES, 2'h1, 13'h0030, 1'b0));
    ctl.drive(pat(P_WR, 2'h1, 13'h0034, 1'b0));
    hold(P_NOP);
    `CHK("wr_vld", 1'b1, cmd_vld_o)
    hold(P_NOP);
    `CHK("desel_busy", 1'b1, burst_busy_o)
    hold(P_NOP);
    `CHK("join_vld", 1'b1, cmd_vld_o)
    `CHK("join_drop", 1'b0, cmd_drop_o)
    `CHK("join_dir", 1'b0, burst_rd_o)
    // Power-down: entry, refresh ignored, exit
    hold(5'h07);
    hold(5'h07);
    hold(5'h01);
    hold(5'h07);
    `CHK("pd_in", ddc_pkg::PW_DOWN, power_o)
    hold(5'h07);
    hold(P_NOP);
    `CHK("pd_noref", 1'b0, refresh_o)
    `CHK("pd_hold", ddc_pkg::PW_DOWN, power_o)
    hold(P_NOP);
    hold(P_NOP);
    hold(P_NOP);
    `CHK("pd_out", ddc_pkg::PW_ACTIVE, power_o)
    // Self refresh with termination requested, then exit
    ctl.drive(pat(5'h01, 2'h0, 13'h0000, 1'b1));
    repeat (3) ctl.drive(pat(5'h07, 2'h0, 13'h0000, 1'b1));
    #1;
    `CHK("sr_in", ddc_pkg::PW_SELF, power_o)
    `CHK("sr_rterm", 1'b0, rterm_on_o)
    for (int k = 0; k < 6 && power_o !== ddc_pkg::PW_ACTIVE; k++) begin
      hold(P_DES);
    end
    `CHK("sr_out", ddc_pkg::PW_ACTIVE, power_o)
    conclude();
  end

endmodule : ddc_decoder_tb

`undef CHK

`default_nettype wire
